// ==== sim/sbrg_props.sv ====
// bus and bit tick assertions for the baud rate generator top
`timescale 1ns/10ps
`default_nettype none
module sbrg_props
    import sbrg_pkg::*;
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [SBRG_AW-1:0] awaddr,
    input wire logic [2:0]         awprot,
    input wire logic               awvalid,
    input wire logic               awready,
    input wire logic [SBRG_DW-1:0] wdata,
    input wire logic [3:0]         wstrb,
    input wire logic               wvalid,
    input wire logic               wready,
    input wire logic [1:0]         bresp,
    input wire logic               bvalid,
    input wire logic               bready,
    input wire logic [SBRG_AW-1:0] araddr,
    input wire logic [2:0]         arprot,
    input wire logic               arvalid,
    input wire logic               arready,
    input wire logic [SBRG_DW-1:0] rdata,
    input wire logic [1:0]         rresp,
    input wire logic               rvalid,
    input wire logic               rready,
    input wire logic               bit_tick
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // shadow of the rate settings rebuilt from accepted writes
    logic [7:0]  ltc_q, rc_q, lo_q, hi_q;
    logic        ok_q;
    int          gap_q;
    int          fac;
    int          per;
    wire         wr_go  = awvalid && awready && wvalid && wready && wstrb[0];
    wire [5:0]   wa     = awaddr[7:2];
    wire         div_wr = wr_go && (wa == 6'h02 || wa == 6'h03);
    wire         ctl_wr = wr_go && (wa == 6'h00 || wa == 6'h01);
    wire [15:0]  n_w    = rc_q[RC_WIDE_BIT] ? {hi_q, lo_q} : {8'h00, lo_q};
    wire         fast_w = ltc_q[LTC_FAST_BIT];
    assign fac = ltc_q[LTC_SYNC_BIT] ? 4 :
                 rc_q[RC_WIDE_BIT] ? (fast_w ? 4 : 16) : (fast_w ? 16 : 64);
    assign per = fac * (n_w + 1);

    // mode writes drop the period check: counters may wrap, not restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ltc_q <= 8'h00;
            rc_q  <= 8'h00;
            lo_q  <= 8'h00;
            hi_q  <= 8'h00;
            ok_q  <= 1'b0;
            gap_q <= 0;
        end else begin
            if (wr_go && wa == 6'h00) ltc_q <= wdata[7:0];
            if (wr_go && wa == 6'h01) rc_q <= wdata[7:0];
            if (wr_go && wa == 6'h02) lo_q <= wdata[7:0];
            if (wr_go && wa == 6'h03) hi_q <= wdata[7:0];
            ok_q  <= div_wr ? 1'b1 : (ctl_wr ? 1'b0 : ok_q);
            // a tick already in flight at the write edge starts no period
            gap_q <= div_wr ? -1 : ((bit_tick && gap_q >= 0) ? 1 : gap_q + 1);
        end
    end

    sequence wr_take_s;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence rd_take_s;
        arvalid && arready;
    endsequence

    tick_pulse_a: assert property (bit_tick |=> !bit_tick)
        else $error("bit tick longer than one cycle");
    restart_hold_a: assert property (
        wr_take_s ##0 div_wr |=> ##2 !bit_tick [*3])
        else $error("tick soon after a divisor write");
    tick_period_a: assert property (
        ok_q && gap_q > 1 && bit_tick |-> gap_q == per)
        else $error("bit tick spacing wrong");
    tick_due_a: assert property (ok_q |-> gap_q <= per)
        else $error("bit tick missing");
    wr_answer_a: assert property (wr_take_s |=> !bvalid ##1 bvalid)
        else $error("write answer late or early");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped");
    rd_answer_a: assert property (rd_take_s |=> rvalid && !arready)
        else $error("read answer late");
    div_read_a: assert property (
        rd_take_s ##0 araddr[7:2] == 6'h03 |=> rdata == {24'h000000, hi_q})
        else $error("divisor high byte read wrong");
    hole_read_a: assert property (
        rd_take_s ##0 araddr[7:2] > 6'h04 |=> rresp == RESP_SLVERR && rdata == '0)
        else $error("unmapped read not refused");
    hole_write_a: assert property (
        wr_take_s ##0 wa > 6'h04 |=> ##1 bvalid && bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule
`default_nettype wire

// ==== sim/tb_serial_baud_rate_generator.sv ====
// self-checking bench for the baud rate generator over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module tb_serial_baud_rate_generator import sbrg_pkg::*;;
    logic               aclk = 1'b0, aresetn = 1'b0;
    logic [SBRG_AW-1:0] awaddr = '0, araddr = '0;
    logic [SBRG_DW-1:0] wdata = '0;
    logic [3:0]         wstrb = 4'h0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid, bit_tick;
    logic [1:0]         bresp, rresp;
    logic [SBRG_DW-1:0] rdata;
    int                 n_errors = 0, comparisons = 0, stall = 0, g, p, i;
    logic [7:0] ltc_v [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
    logic [7:0] rc_v  [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    logic [7:0] hi_v  [6] = '{8'h05, 8'h05, 8'h01, 8'h01, 8'h05, 8'h01};
    logic [7:0] lo_v  [6] = '{8'h02, 8'h01, 8'h02, 8'h02, 8'h03, 8'h02};

    sbrg_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'b000), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'b000),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .bit_tick(bit_tick));

    // 50 MHz clock
    always #10 aclk = ~aclk;

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic ad, wd;
        int   k;
        ad = 1'b0;
        wd = 1'b0;
        k = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(ad && wd) && ++k < 40);
        repeat (stall) @(posedge aclk);
        bready <= 1'b1;
        k = 0;
        do @(posedge aclk); while (bvalid !== 1'b1 && ++k < 40);
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1 && ++k < 40);
        arvalid <= 1'b0;
        repeat (stall) @(posedge aclk);
        rready <= 1'b1;
        k = 0;
        do @(posedge aclk); while (rvalid !== 1'b1 && ++k < 40);
        chk("rvalid", 32'h1, {31'h0, rvalid});
        chk("rdata", ed, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask

    // edges from the call until the tick is seen
    task automatic gap_to_tick(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (bit_tick !== 1'b1 && n < 5000);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // the whole run takes about 20k cycles, so 40k leaves wide margin
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        $display("Error watchdog expected finish seen timeout");
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        stall = 2;
        rd(OFF_LINE_TX_CTL, 32'h2, RESP_OKAY);
        rd(OFF_RATE_CTL, 32'h0, RESP_OKAY);
        rd(OFF_DIV_LOW, 32'h0, RESP_OKAY);
        rd(OFF_DIV_HIGH, 32'h0, RESP_OKAY);
        wr(OFF_DIV_HIGH, 32'hffff_ffa5, 4'hf, RESP_OKAY);
        rd(OFF_DIV_HIGH, 32'ha5, RESP_OKAY);
        wr(OFF_DIV_HIGH, 32'h5a, 4'h0, RESP_OKAY);
        rd(OFF_DIV_HIGH, 32'ha5, RESP_OKAY);
        // narrow with a zero low byte never lets the divisor count leave 0
        rd(OFF_COUNT_STATUS, 32'h0, RESP_OKAY);
        wr(OFF_LINE_TX_CTL, 32'h0, 4'hf, RESP_OKAY);
        rd(OFF_LINE_TX_CTL, 32'h2, RESP_OKAY);
        wr(8'h14, 32'h1, 4'hf, RESP_SLVERR);
        rd(8'h14, 32'h0, RESP_SLVERR);
        stall = 0;
        $display("test registers done");
        for (i = 0; i < 6; i++) begin
            p = ltc_v[i][4] ? 4 : rc_v[i][3] ? (ltc_v[i][2] ? 4 : 16)
                                             : (ltc_v[i][2] ? 16 : 64);
            p = p * ((rc_v[i][3] ? {hi_v[i], lo_v[i]} : lo_v[i]) + 1);
            wr(OFF_LINE_TX_CTL, {24'h0, ltc_v[i]}, 4'hf, RESP_OKAY);
            wr(OFF_RATE_CTL, {24'h0, rc_v[i]}, 4'hf, RESP_OKAY);
            wr(OFF_DIV_LOW, {24'h0, lo_v[i]}, 4'hf, RESP_OKAY);
            wr(OFF_DIV_HIGH, {24'h0, hi_v[i]}, 4'hf, RESP_OKAY);
            gap_to_tick(g);
            chk("first tick after high write", 32'(p), 32'(g));
            gap_to_tick(g);
            chk("tick period", 32'(p), 32'(g));
            wr(OFF_DIV_LOW, {24'h0, lo_v[i]}, 4'hf, RESP_OKAY);
            gap_to_tick(g);
            chk("first tick after low write", 32'(p), 32'(g));
            $display("test rate case %0d done", i);
        end
        // a second reset in mid-run must clear the divisor bytes again
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_DIV_HIGH, 32'h0, RESP_OKAY);
        rd(OFF_DIV_LOW, 32'h0, RESP_OKAY);
        rd(OFF_RATE_CTL, 32'h0, RESP_OKAY);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule

bind sbrg_top sbrg_props u_props (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .bit_tick(bit_tick));
`default_nettype wire

// ==== src/sbrg_pkg.sv ====
// shared constants and types of the serial baud rate generator
package sbrg_pkg;

    // register bus geometry
    localparam int unsigned SBRG_AW = 8;
    localparam int unsigned SBRG_DW = 32;

    // register byte addresses
    localparam logic [SBRG_AW-1:0] OFF_LINE_TX_CTL  = 8'h00;
    localparam logic [SBRG_AW-1:0] OFF_RATE_CTL     = 8'h04;
    localparam logic [SBRG_AW-1:0] OFF_DIV_LOW      = 8'h08;
    localparam logic [SBRG_AW-1:0] OFF_DIV_HIGH     = 8'h0c;
    localparam logic [SBRG_AW-1:0] OFF_COUNT_STATUS = 8'h10;

    // line_transmit_control field positions
    localparam int unsigned LTC_SYNC_BIT = 4;
    localparam int unsigned LTC_FAST_BIT = 2;
    localparam int unsigned LTC_IDLE_BIT = 1;
    localparam logic [7:0]  LTC_WR_MASK  = 8'hfd;
    localparam logic [7:0]  LTC_RESET    = 8'h00;

    // rate_control field positions
    localparam int unsigned RC_WIDE_BIT = 3;
    localparam logic [7:0]  RC_WR_MASK  = 8'h1b;
    localparam logic [7:0]  RC_RESET    = 8'h00;

    // divisor byte reset values
    localparam logic [7:0] DIV_LOW_RESET  = 8'h00;
    localparam logic [7:0] DIV_HIGH_RESET = 8'h00;

    // prescale terminal counts: divide by 64, 16 and 4
    localparam logic [5:0] PRE_TERM_64 = 6'h3f;
    localparam logic [5:0] PRE_TERM_16 = 6'h0f;
    localparam logic [5:0] PRE_TERM_4  = 6'h03;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // rate settings handed to the counting logic
    typedef struct packed {
        logic        sync_mode;
        logic        wide_sel;
        logic        fast_sel;
        logic [15:0] divisor;
    } sbrg_cfg_s;

    // bus channel states, one-hot
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } sbrg_wr_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } sbrg_rd_e;

endpackage

// ==== src/sbrg_prescaler.sv ====
// prescaler that divides the clock by the mode-selected factor
`timescale 1ns/10ps
`default_nettype none
module sbrg_prescaler
    import sbrg_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire sbrg_cfg_s  cfg,
    input  wire logic       clear,
    output var  logic       pre_tick
);

    logic [5:0] term;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;

    // factor choice: sync 4, async by width and speed
    assign term = cfg.sync_mode ? PRE_TERM_4 :             // see R08
                  (!cfg.wide_sel && !cfg.fast_sel) ? PRE_TERM_64 : // see R06
                  (cfg.wide_sel && cfg.fast_sel) ? PRE_TERM_4 :    // see R09
                  PRE_TERM_16;                             // see R07 R09

    // a shrinking factor may leave cnt above term, so wrap on >=
    assign pre_tick = !clear && (cnt_q >= term);
    assign cnt_d    = (clear || pre_tick) ? 6'h00 : cnt_q + 6'h01;

    // divisor writes restart the prescale phase too
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;                                // see R03 R04
        end
    end

endmodule
`default_nettype wire

// ==== src/sbrg_rate_counter.sv ====
// divisor counter that emits one bit tick per n+1 prescale ticks
`timescale 1ns/10ps
`default_nettype none
module sbrg_rate_counter
    import sbrg_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire sbrg_cfg_s   cfg,
    input  wire logic        clear,
    input  wire logic        pre_tick,
    output var  logic [15:0] count_q,
    output var  logic        bit_tick_q
);

    logic [15:0] n_eff;
    logic        at_end;

    // narrow generator ignores the high byte in every mode
    assign n_eff  = cfg.wide_sel ? cfg.divisor             // see R05
                                 : {8'h00, cfg.divisor[7:0]}; // see R02
    // counting up and comparing to the live n avoids a stale reload
    assign at_end = count_q >= n_eff;

    // count prescale ticks, restart on any divisor write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q    <= 16'h0000;
            bit_tick_q <= 1'b0;
        end else if (clear) begin
            count_q    <= 16'h0000;                        // see R03 R04
            bit_tick_q <= 1'b0;
        end else if (pre_tick) begin
            count_q    <= at_end ? 16'h0000 : count_q + 16'h0001;
            bit_tick_q <= at_end;
        end else begin
            bit_tick_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== src/sbrg_top.sv ====
// baud rate generator with its register file on an axi4-lite slave
//
// Behaviour
// R01: divisor high byte is a read/write 8-bit register, zero after reset.
// R02: with the wide select clear, only the low divisor byte is counted.
// R03: writing the divisor high byte restarts the generator count.
// R04: writing the divisor low byte restarts the generator count.
// R05: divisor n is high byte above low byte.
// R06: async, narrow, slow: bit rate is clock over 64 times (n+1).
// R07: async, wide, slow: bit rate is clock over 16 times (n+1).
// R08: sync mode: clock over 4 times (n+1), speed select ignored.
// R09: async fast: 16 times (n+1) narrow, 4 times (n+1) wide.
`timescale 1ns/10ps
`default_nettype none
module sbrg_top
    import sbrg_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // write address channel
    input  wire logic [SBRG_AW-1:0] awaddr,
    input  wire logic [2:0]         awprot,
    input  wire logic               awvalid,
    output var  logic               awready,
    // write data channel
    input  wire logic [SBRG_DW-1:0] wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output var  logic               wready,
    // write response channel
    output var  logic [1:0]         bresp,
    output var  logic               bvalid,
    input  wire logic               bready,
    // read address channel
    input  wire logic [SBRG_AW-1:0] araddr,
    input  wire logic [2:0]         arprot,
    input  wire logic               arvalid,
    output var  logic               arready,
    // read data channel
    output var  logic [SBRG_DW-1:0] rdata,
    output var  logic [1:0]         rresp,
    output var  logic               rvalid,
    input  wire logic               rready,
    // bit clock enable to the transmitter and receiver
    output var  logic               bit_tick
);

    // word-aligned address match, shared by both channels
    function automatic logic addr_hit(
        input logic [SBRG_AW-1:0] addr,
        input logic [SBRG_AW-1:0] off
    );
        addr_hit = (addr[SBRG_AW-1:2] == off[SBRG_AW-1:2]);
    endfunction

    // any of the five registers
    function automatic logic addr_mapped(
        input logic [SBRG_AW-1:0] addr
    );
        addr_mapped = addr_hit(addr, OFF_LINE_TX_CTL)
                    | addr_hit(addr, OFF_RATE_CTL)
                    | addr_hit(addr, OFF_DIV_LOW)
                    | addr_hit(addr, OFF_DIV_HIGH)
                    | addr_hit(addr, OFF_COUNT_STATUS);
    endfunction

    // ------------------------------------------------------------
    // bus state
    // ------------------------------------------------------------

    sbrg_wr_e            wr_state_q;
    sbrg_rd_e            rd_state_q;

    logic                awready_q;
    logic                wready_q;
    logic                aw_held_q;
    logic                w_held_q;
    logic [SBRG_AW-1:0]  awaddr_q;
    logic [7:0]          wbyte_q;
    logic                wlane_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;

    logic                arready_q;
    logic                rvalid_q;
    logic [1:0]          rresp_q;
    logic [SBRG_DW-1:0]  rdata_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    logic [7:0]          ltc_q;
    logic [7:0]          rc_q;
    logic [7:0]          div_low_q;
    logic [7:0]          div_high_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------

    logic                aw_take;
    logic                w_take;
    logic                ar_take;
    logic                do_write;
    logic                wr_mapped;
    logic                wr_byte;
    logic                wr_ltc;
    logic                wr_rc;
    logic                wr_low;
    logic                wr_high;
    logic                div_clear;
    logic [SBRG_DW-1:0]  rd_word;
    logic                rd_mapped;

    sbrg_cfg_s           cfg;
    logic                pre_tick;
    logic [15:0]         count_q;
    logic                bit_tick_q;

    // channel handshakes
    assign aw_take = awvalid && awready_q;
    assign w_take  = wvalid && wready_q;
    assign ar_take = arvalid && arready_q;

    // a write is carried out once both halves are held
    assign do_write  = (wr_state_q == WR_IDLE) && aw_held_q && w_held_q;
    assign wr_mapped = addr_mapped(awaddr_q);
    // all writable registers live in byte lane 0; other lanes are ignored
    assign wr_byte   = do_write && wlane_q;

    assign wr_ltc  = wr_byte && addr_hit(awaddr_q, OFF_LINE_TX_CTL);
    assign wr_rc   = wr_byte && addr_hit(awaddr_q, OFF_RATE_CTL);
    assign wr_low  = wr_byte && addr_hit(awaddr_q, OFF_DIV_LOW);
    assign wr_high = wr_byte && addr_hit(awaddr_q, OFF_DIV_HIGH);

    // either divisor byte written restarts the count at once
    assign div_clear = wr_low || wr_high;                  // see R03 R04

    // read mux; narrow registers sit in the low bits
    assign rd_mapped = addr_mapped(araddr);
    assign rd_word =
        addr_hit(araddr, OFF_LINE_TX_CTL)  ? {24'h000000, ltc_q} :
        addr_hit(araddr, OFF_RATE_CTL)     ? {24'h000000, rc_q} :
        addr_hit(araddr, OFF_DIV_LOW)      ? {24'h000000, div_low_q} :
        addr_hit(araddr, OFF_DIV_HIGH)     ? {24'h000000, div_high_q} :
        addr_hit(araddr, OFF_COUNT_STATUS) ? {16'h0000, count_q} :
        32'h00000000;

    // settings handed to the counting logic
    assign cfg.sync_mode = ltc_q[LTC_SYNC_BIT];
    assign cfg.fast_sel  = ltc_q[LTC_FAST_BIT];
    assign cfg.wide_sel  = rc_q[RC_WIDE_BIT];
    assign cfg.divisor   = {div_high_q, div_low_q};        // see R05

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------

    // transmit shifter is absent, so its empty flag always reads set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ltc_q <= LTC_RESET | (8'h01 << LTC_IDLE_BIT);
        end else if (wr_ltc) begin
            ltc_q <= (wbyte_q & LTC_WR_MASK) | (8'h01 << LTC_IDLE_BIT);
        end
    end

    // rate control: read-only and unused bits stay zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_q <= RC_RESET;
        end else if (wr_rc) begin
            rc_q <= wbyte_q & RC_WR_MASK;
        end
    end

    // divisor byte pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_low_q  <= DIV_LOW_RESET;
            div_high_q <= DIV_HIGH_RESET;                  // see R01
        end else begin
            if (wr_low) begin
                div_low_q <= wbyte_q;
            end
            if (wr_high) begin
                div_high_q <= wbyte_q;                     // see R01
            end
        end
    end

    // ------------------------------------------------------------
    // write channels: address and data taken in either order
    // ------------------------------------------------------------

    // each ready drops once its half is held, so nothing is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= WR_IDLE;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            awaddr_q   <= '0;
            wbyte_q    <= 8'h00;
            wlane_q    <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q  <= awaddr;
                aw_held_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (w_take) begin
                wbyte_q  <= wdata[7:0];
                wlane_q  <= wstrb[0];
                w_held_q <= 1'b1;
                wready_q <= 1'b0;
            end
            case (wr_state_q)
                WR_IDLE: begin
                    if (do_write) begin
                        bvalid_q   <= 1'b1;
                        bresp_q    <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
                        wr_state_q <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        bvalid_q   <= 1'b0;
                        aw_held_q  <= 1'b0;
                        w_held_q   <= 1'b0;
                        awready_q  <= 1'b1;
                        wready_q   <= 1'b1;
                        wr_state_q <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= WR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read channels
    // ------------------------------------------------------------

    // data is sampled at the address handshake and then held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= RD_IDLE;
            arready_q  <= 1'b1;
            rvalid_q   <= 1'b0;
            rresp_q    <= RESP_OKAY;
            rdata_q    <= 32'h00000000;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (ar_take) begin
                        rdata_q    <= rd_word;
                        rresp_q    <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                        rvalid_q   <= 1'b1;
                        arready_q  <= 1'b0;
                        rd_state_q <= RD_DATA;
                    end
                end
                RD_DATA: begin
                    if (rready) begin
                        rvalid_q   <= 1'b0;
                        arready_q  <= 1'b1;
                        rd_state_q <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= RD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // rate generation
    // ------------------------------------------------------------

    // prescaler picks 64, 16 or 4 from the mode bits
    sbrg_prescaler u_prescaler (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cfg      (cfg),
        .clear    (div_clear),
        .pre_tick (pre_tick)
    );

    // divisor counter adds the (n+1) factor
    sbrg_rate_counter u_rate_counter (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cfg        (cfg),
        .clear      (div_clear),
        .pre_tick   (pre_tick),
        .count_q    (count_q),
        .bit_tick_q (bit_tick_q)
    );

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------

    assign awready  = awready_q;
    assign wready   = wready_q;
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;
    assign arready  = arready_q;
    assign rvalid   = rvalid_q;
    assign rresp    = rresp_q;
    assign rdata    = rdata_q;
    assign bit_tick = bit_tick_q;                          // see R06 R07 R08 R09

endmodule
`default_nettype wire
